// ===== svrw_map.svh
/*
 * Constants of the supervisor: register offsets, field positions, reset
 * values, identifiers and timing figures. Included by both link ends.
 */
`ifndef SVRW_MAP_SVH
`define SVRW_MAP_SVH

// ==========================================================================
// Timing
`define SVRW_CLK_NS 32'h00000004
`define SVRW_TICK_NS 32'h000F4240
`define SVRW_RST_MS0 8'h19
`define SVRW_RST_MS1 8'h32
`define SVRW_RST_MS2 8'h64
`define SVRW_RST_MS3 8'hC8
`define SVRW_WD_MS3 12'h190
`define SVRW_WD_MS4 12'h320
`define SVRW_WD_MS5 12'h640
`define SVRW_WD_MS6 12'hC80
`define SVRW_WD_MS7 12'hC80

// ==========================================================================
// Device register space
`define SVRW_ADDR_CFG 8'h00
`define SVRW_ADDR_PR0 8'h01
`define SVRW_ADDR_PR1 8'h02
`define SVRW_CFG_RST 8'h58
`define SVRW_PR0_RST 8'h04
`define SVRW_PR1_RST 8'h00
`define SVRW_CFG_LOCK 7
`define SVRW_CODE_HI 6
`define SVRW_CODE_LO 4
`define SVRW_PR0_RT_HI 6
`define SVRW_PR0_RT_LO 5
`define SVRW_PR1_LOCK 6
`define SVRW_PR1_POL 5
`define SVRW_PR1_DT 3
`define SVRW_CODE_MIN 3'h1
`define SVRW_CODE_MAX 3'h6
`define SVRW_CODE_MR 3'h4
`define SVRW_ID_MEM 4'hA
`define SVRW_ID_MEM_ALT 4'hB
`define SVRW_ID_REG 4'h9

// ==========================================================================
// Controller register space
`define SVRW_H_CMD 8'h00
`define SVRW_H_STAT 8'h04
`define SVRW_H_DIV 8'h08
`define SVRW_H_KICK 8'h0C
`define SVRW_H_DIV_RST 16'h0005
`define SVRW_H_START 8
`define SVRW_H_STOP 9
`define SVRW_H_READ 10
`define SVRW_H_ACK 11

`endif

// ===== svrw_pkg.sv
/*
 * State types of both link ends.
 * Assumes nothing of its surroundings.
 */
package svrw_pkg;

    typedef enum logic [2:0] {
        S_IDLE,
        S_RX,
        S_ACK,
        S_TX,
        S_TXACK
    } svrw_dev_state_t;

    typedef enum logic [1:0] {
        H_IDLE,
        H_START,
        H_BIT,
        H_STOP
    } svrw_host_state_t;

endpackage : svrw_pkg

// ===== svrw_if.sv
/*
 * Two-wire link between the controller and the supervisor.
 * Assumes both ends drive the data line open-drain; the clock line is
 * driven only by the controller.
 */
interface svrw_if;

    logic scl;
    logic m_sda_o;
    logic m_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic sda;

    // Wired-AND of the data line with a pull-up
    assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

    modport host (output scl, output m_sda_o, output m_sda_oe, input sda);
    modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);

endinterface : svrw_if

// ===== svrw_dev.sv
/*
 * Supervisor control logic: reset stretcher, watchdog, register space and
 * 2K x 8 memory behind a two-wire slave.
 * Assumes comparator results and pins arrive asynchronously; the master
 * holds SCL low and high for at least four clock cycles each.
 */
`include "svrw_map.svh"
module svrw_dev #(
    parameter int TICK_CYC = `SVRW_TICK_NS / `SVRW_CLK_NS,
    parameter int DEPTH = 2048
) (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_clk_en,
    // Two-wire link
    svrw_if.dev link,
    // Comparators and pins
    input wire logic i_vcc_low,
    input wire logic i_sense_above,
    input wire logic i_manual_reset_n,
    input wire logic i_watchdog_kick_in,
    input wire logic i_write_lockout_in,
    // Supervisor outputs
    output logic o_reset_n,
    output logic o_reset,
    output logic [1:0] o_aux_reset_n,
    output logic o_low_voltage_flag_n,
    output logic [4:0] o_threshold_sel,
    output logic [3:0] o_threshold_trim
);

    localparam int TW = $clog2(TICK_CYC);
    localparam int AW = $clog2(DEPTH);

    function automatic logic [7:0] rst_ms(input logic [1:0] sel);
        case (sel)
            2'h0: rst_ms = `SVRW_RST_MS0;
            2'h1: rst_ms = `SVRW_RST_MS1;
            2'h2: rst_ms = `SVRW_RST_MS2;
            default: rst_ms = `SVRW_RST_MS3;
        endcase
    endfunction : rst_ms

    function automatic logic [11:0] wd_ms(input logic [2:0] sel);
        case (sel)
            3'h3: wd_ms = `SVRW_WD_MS3;
            3'h4: wd_ms = `SVRW_WD_MS4;
            3'h5: wd_ms = `SVRW_WD_MS5;
            3'h6: wd_ms = `SVRW_WD_MS6;
            3'h7: wd_ms = `SVRW_WD_MS7;
            default: wd_ms = 12'h000;
        endcase
    endfunction : wd_ms

    function automatic logic code_ok(input logic [2:0] c);
        code_ok = (c >= `SVRW_CODE_MIN) && (c <= `SVRW_CODE_MAX);
    endfunction : code_ok

    // ======================================================================
    // Input synchronisers
    logic [6:0] pin_m_q;
    logic [6:0] pin_s_q;
    logic [2:0] prev_q;
    wire [6:0] pin_raw = {link.scl, link.sda, i_manual_reset_n, i_watchdog_kick_in,
                          i_write_lockout_in, i_vcc_low, i_sense_above};
    wire scl_s = pin_s_q[6];
    wire sda_s = pin_s_q[5];
    wire mr_n_s = pin_s_q[4];
    wire wdi_s = pin_s_q[3];
    wire wf_s = pin_s_q[2];
    wire low_voltage_flag_n_s = pin_s_q[1];
    wire above_s = pin_s_q[0];

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            pin_m_q <= 7'h70; // Idle pin levels, so no false edge follows reset
            pin_s_q <= 7'h70;
            prev_q <= 3'h6;
        end else if (i_clk_en) begin
            pin_m_q <= pin_raw;
            pin_s_q <= pin_m_q;
            prev_q <= {scl_s, sda_s, wdi_s};
        end
    end

    wire scl_rise = scl_s & ~prev_q[2];
    wire scl_fall = ~scl_s & prev_q[2];
    wire start_ev = scl_s & prev_q[2] & prev_q[1] & ~sda_s;
    wire stop_ev = scl_s & prev_q[2] & ~prev_q[1] & sda_s;
    wire kick = wdi_s ^ prev_q[0];

    // ======================================================================
    // Registers and variant decode
    logic [7:0] cfg_q;
    logic [7:0] pr0_q;
    logic [7:0] pr1_q;
    wire [2:0] code = cfg_q[`SVRW_CODE_HI:`SVRW_CODE_LO];
    wire is_mr_var = (code == `SVRW_CODE_MR);
    wire has_rst_hi = (code == 3'h1) | (code == 3'h3) | (code == 3'h5);
    wire has_sense = (code == 3'h5) | (code == 3'h6);
    wire sense_trig = pr1_q[`SVRW_PR1_POL] ? ~above_s : above_s;
    wire [3:0] mem_id = pr1_q[`SVRW_PR1_DT] ? `SVRW_ID_MEM_ALT : `SVRW_ID_MEM;

    // ======================================================================
    // Timebase, reset stretcher and watchdog
    logic [TW-1:0] pre_q;
    logic [7:0] rst_cnt_q;
    logic [11:0] wd_cnt_q;
    logic wd_exp_q;
    wire tick = (pre_q == TW'(TICK_CYC - 1));
    wire [11:0] wd_lim = wd_ms(pr1_q[2:0]);
    wire wd_off = (wd_lim == 12'h000);
    wire mr_cause = is_mr_var & ~mr_n_s;
    wire aux_cause = is_mr_var & ~above_s;
    wire cause = low_voltage_flag_n_s | mr_cause | aux_cause | wd_exp_q;
    wire rst_act = cause | (rst_cnt_q != 8'h00);

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            pre_q <= '0;
            rst_cnt_q <= 8'h00;
            wd_cnt_q <= 12'h000;
            wd_exp_q <= 1'b0;
        end else if (i_clk_en) begin
            pre_q <= tick ? '0 : pre_q + 1'b1;
            if (cause) begin
                rst_cnt_q <= rst_ms(pr0_q[`SVRW_PR0_RT_HI:`SVRW_PR0_RT_LO]);
            end else if (tick && rst_cnt_q != 8'h00) begin
                rst_cnt_q <= rst_cnt_q - 8'h01;
            end
            wd_exp_q <= 1'b0;
            if (wd_off || kick || rst_act) begin
                wd_cnt_q <= 12'h000;
            end else if (tick) begin
                if (wd_cnt_q == wd_lim - 12'h001) begin
                    wd_cnt_q <= 12'h000;
                    wd_exp_q <= 1'b1;
                end else begin
                    wd_cnt_q <= wd_cnt_q + 12'h001;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_reset_n <= 1'b0;
            o_reset <= 1'b0;
            o_aux_reset_n <= 2'h3;
            o_low_voltage_flag_n <= 1'b1;
            o_threshold_sel <= 5'h00;
            o_threshold_trim <= 4'h0;
        end else if (i_clk_en) begin
            o_reset_n <= ~rst_act;
            o_reset <= has_rst_hi & rst_act;
            o_aux_reset_n <= {2{~(is_mr_var & rst_act)}};
            o_low_voltage_flag_n <= ~(has_sense & sense_trig);
            o_threshold_sel <= pr0_q[4:0];
            o_threshold_trim <= cfg_q[3:0];
        end
    end

    // ======================================================================
    // Two-wire slave
    svrw_pkg::svrw_dev_state_t st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [1:0] phase_q;
    logic is_rd_q;
    logic is_reg_q;
    logic m_ack_q;
    logic [AW-1:0] ptr_q;
    logic oe_q;
    logic [7:0] mem_q [DEPTH];

    wire reg_hit = (sh_q[7:4] == `SVRW_ID_REG);
    wire hit = reg_hit | (sh_q[7:4] == mem_id);
    wire byte_done = (st_q == svrw_pkg::S_RX) & scl_fall & (bit_q == 4'h8);
    wire wr_byte = byte_done & (phase_q == 2'h2) & ~wf_s;
    wire wr_mem = wr_byte & ~is_reg_q;
    wire wr_reg = wr_byte & is_reg_q;
    wire [7:0] roff = ptr_q[7:0];
    wire cfg_we = wr_reg & (roff == `SVRW_ADDR_CFG) & ~cfg_q[`SVRW_CFG_LOCK]
                  & code_ok(sh_q[`SVRW_CODE_HI:`SVRW_CODE_LO]);
    wire pr0_we = wr_reg & (roff == `SVRW_ADDR_PR0) & ~pr1_q[`SVRW_PR1_LOCK];
    wire pr1_we = wr_reg & (roff == `SVRW_ADDR_PR1) & ~pr1_q[`SVRW_PR1_LOCK];
    wire [7:0] reg_rd = (roff == `SVRW_ADDR_CFG) ? cfg_q :
                        (roff == `SVRW_ADDR_PR0) ? pr0_q :
                        (roff == `SVRW_ADDR_PR1) ? pr1_q : 8'h00;
    wire [7:0] rd_data = is_reg_q ? reg_rd : mem_q[ptr_q];
    wire [7:0] tx_sh = {rd_data[6:0], 1'b0};

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cfg_q <= `SVRW_CFG_RST;
            pr0_q <= `SVRW_PR0_RST;
            pr1_q <= `SVRW_PR1_RST;
        end else if (i_clk_en) begin
            if (cfg_we) cfg_q <= sh_q;
            if (pr0_we) pr0_q <= sh_q;
            if (pr1_we) pr1_q <= sh_q;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_clk_en && wr_mem) begin
            mem_q[ptr_q] <= sh_q;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st_q <= svrw_pkg::S_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            phase_q <= 2'h0;
            is_rd_q <= 1'b0;
            is_reg_q <= 1'b0;
            m_ack_q <= 1'b0;
            ptr_q <= '0;
            oe_q <= 1'b0;
        end else if (i_clk_en) begin
            if (start_ev) begin
                st_q <= svrw_pkg::S_RX;
                bit_q <= 4'h0;
                phase_q <= 2'h0;
                oe_q <= 1'b0;
            end else if (stop_ev) begin
                st_q <= svrw_pkg::S_IDLE;
                oe_q <= 1'b0;
            end else begin
                case (st_q)
                    svrw_pkg::S_RX: begin
                        if (scl_rise) begin
                            sh_q <= {sh_q[6:0], sda_s};
                            bit_q <= bit_q + 4'h1;
                        end else if (byte_done) begin
                            bit_q <= 4'h0;
                            if (phase_q != 2'h0) begin
                                oe_q <= 1'b1;
                                st_q <= svrw_pkg::S_ACK;
                                if (phase_q == 2'h1) ptr_q[7:0] <= sh_q;
                                else ptr_q[3:0] <= ptr_q[3:0] + 4'h1;
                            end else if (hit) begin
                                oe_q <= 1'b1;
                                st_q <= svrw_pkg::S_ACK;
                                is_rd_q <= sh_q[0];
                                is_reg_q <= reg_hit;
                                if (!reg_hit) ptr_q[AW-1:8] <= sh_q[3:1];
                            end else begin
                                st_q <= svrw_pkg::S_IDLE;
                            end
                        end
                    end
                    svrw_pkg::S_ACK: begin
                        if (scl_fall && is_rd_q) begin
                            st_q <= svrw_pkg::S_TX;
                            sh_q <= tx_sh;
                            oe_q <= ~rd_data[7];
                            bit_q <= 4'h1;
                        end else if (scl_fall) begin
                            st_q <= svrw_pkg::S_RX;
                            oe_q <= 1'b0;
                            phase_q <= (phase_q == 2'h0) ? 2'h1 : 2'h2;
                        end
                    end
                    svrw_pkg::S_TX: begin
                        if (scl_fall && bit_q == 4'h8) begin
                            oe_q <= 1'b0;
                            st_q <= svrw_pkg::S_TXACK;
                            ptr_q <= ptr_q + 1'b1;
                        end else if (scl_fall) begin
                            oe_q <= ~sh_q[7];
                            sh_q <= {sh_q[6:0], 1'b0};
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                    svrw_pkg::S_TXACK: begin
                        if (scl_rise) begin
                            m_ack_q <= ~sda_s;
                        end else if (scl_fall && m_ack_q) begin
                            st_q <= svrw_pkg::S_TX;
                            sh_q <= tx_sh;
                            oe_q <= ~rd_data[7];
                            bit_q <= 4'h1;
                        end else if (scl_fall) begin
                            st_q <= svrw_pkg::S_IDLE;
                        end
                    end
                    default: st_q <= svrw_pkg::S_IDLE;
                endcase
            end
        end
    end

    // Only the data line is ever driven, and only low
    assign link.d_sda_oe = oe_q;
    assign link.d_sda_o = 1'b0;

endmodule : svrw_dev

// ===== svrw_host.sv
/*
 * Two-wire bus master with an APB register port and a watchdog kick pin.
 * Assumes an APB master on the same clock; the link data line is
 * asynchronous to it.
 */
`include "svrw_map.svh"
module svrw_host (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_clk_en,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Two-wire link and watchdog
    svrw_if.host link,
    output logic o_watchdog_kick
);

    // ======================================================================
    // APB decode
    logic [11:0] cmd_q;
    logic [15:0] div_q;
    logic busy_q;
    logic ack_q;
    logic [7:0] rx_q;
    wire setup = i_psel & ~i_penable;
    wire fire = i_psel & i_penable & o_pready;
    wire wr = fire & i_pwrite;
    wire a_cmd = (i_paddr == `SVRW_H_CMD);
    wire a_stat = (i_paddr == `SVRW_H_STAT);
    wire a_div = (i_paddr == `SVRW_H_DIV);
    wire a_kick = (i_paddr == `SVRW_H_KICK);
    wire mapped = a_cmd | a_stat | a_div | a_kick;
    wire go = wr & a_cmd & ~busy_q;
    wire [31:0] rdata = a_cmd ? {20'h00000, cmd_q} :
                        a_stat ? {16'h0000, rx_q, 6'h00, ack_q, busy_q} :
                        a_div ? {16'h0000, div_q} : 32'h00000000;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
            div_q <= `SVRW_H_DIV_RST;
            o_watchdog_kick <= 1'b0;
        end else if (i_clk_en) begin
            o_pready <= setup;
            if (setup) o_prdata <= rdata;
            if (setup) o_pslverr <= ~mapped;
            if (wr && a_div) div_q <= i_pwdata[15:0];
            if (wr && a_kick) o_watchdog_kick <= ~o_watchdog_kick;
        end
    end

    // ======================================================================
    // Bit engine
    svrw_pkg::svrw_host_state_t st_q;
    logic [15:0] cnt_q;
    logic [1:0] q_q;
    logic [3:0] bitn_q;
    logic scl_q;
    logic oe_q;
    logic sda_m_q;
    logic sda_s_q;
    wire tick = (cnt_q == 16'h0000);
    wire last = (bitn_q == 4'h8);
    wire rd = cmd_q[`SVRW_H_READ];
    wire [2:0] idx = 3'h7 - bitn_q[2:0];
    wire bit_v = last ? (rd ? ~cmd_q[`SVRW_H_ACK] : 1'b1) : (rd | cmd_q[idx]);

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else if (i_clk_en) begin
            sda_m_q <= link.sda;
            sda_s_q <= sda_m_q;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st_q <= svrw_pkg::H_IDLE;
            cnt_q <= 16'h0000;
            q_q <= 2'h0;
            bitn_q <= 4'h0;
            scl_q <= 1'b1;
            oe_q <= 1'b0;
            busy_q <= 1'b0;
            ack_q <= 1'b0;
            rx_q <= 8'h00;
            cmd_q <= 12'h000;
        end else if (i_clk_en) begin
            cnt_q <= tick ? div_q : cnt_q - 16'h0001;
            if (go) begin
                cmd_q <= i_pwdata[11:0];
                busy_q <= 1'b1;
                q_q <= 2'h0;
                bitn_q <= 4'h0;
                st_q <= i_pwdata[`SVRW_H_START] ? svrw_pkg::H_START : svrw_pkg::H_BIT;
            end else if (tick && busy_q) begin
                q_q <= q_q + 2'h1;
                case (st_q)
                    svrw_pkg::H_START: begin
                        if (q_q == 2'h0) oe_q <= 1'b0;
                        if (q_q == 2'h1) scl_q <= 1'b1;
                        if (q_q == 2'h2) oe_q <= 1'b1;
                        if (q_q == 2'h3) begin
                            scl_q <= 1'b0;
                            st_q <= svrw_pkg::H_BIT;
                        end
                    end
                    svrw_pkg::H_BIT: begin
                        if (q_q == 2'h0) oe_q <= ~bit_v;
                        if (q_q == 2'h1) scl_q <= 1'b1;
                        if (q_q == 2'h2 && !last) rx_q <= {rx_q[6:0], sda_s_q};
                        if (q_q == 2'h2 && last) ack_q <= ~sda_s_q;
                        if (q_q == 2'h3) begin
                            scl_q <= 1'b0;
                            bitn_q <= bitn_q + 4'h1;
                            if (last && cmd_q[`SVRW_H_STOP]) begin
                                st_q <= svrw_pkg::H_STOP;
                            end else if (last) begin
                                oe_q <= 1'b0;
                                busy_q <= 1'b0;
                                st_q <= svrw_pkg::H_IDLE;
                            end
                        end
                    end
                    svrw_pkg::H_STOP: begin
                        if (q_q == 2'h0) oe_q <= 1'b1;
                        if (q_q == 2'h1) scl_q <= 1'b1;
                        if (q_q == 2'h2) oe_q <= 1'b0;
                        if (q_q == 2'h3) begin
                            busy_q <= 1'b0;
                            st_q <= svrw_pkg::H_IDLE;
                        end
                    end
                    default: st_q <= svrw_pkg::H_IDLE;
                endcase
            end
        end
    end

    assign link.scl = scl_q;
    assign link.m_sda_oe = oe_q;
    assign link.m_sda_o = 1'b0;

endmodule : svrw_host

// ===== svrw_props.sv
/* Link checker for the two-wire link.
   Assumes the bench instantiates it beside the interface. */
module svrw_props (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Link
    input wire logic scl,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic d_sda_o,
    input wire logic d_sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);
    AST_RST_IDLE: assert property ($fell(i_srst) |-> scl && !m_sda_oe && !d_sda_oe)
        else $error("link not idle after reset");
    AST_ONE_DRIVER: assert property (scl |-> !(d_sda_oe && m_sda_oe))
        else $error("both ends pull data while clock high");
    AST_HOST_OPEN_DRAIN: assert property (m_sda_o == 1'b0)
        else $error("master drives data high");
    AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*4])
        else $error("clock high too short");
    AST_SCL_LOW_MIN: assert property ($fell(scl) |-> !scl [*4])
        else $error("clock low too short");
    AST_DEV_RISE_LOW: assert property ($rose(d_sda_oe) |-> !scl)
        else $error("device pulls data while clock high");
    AST_DEV_FALL_LOW: assert property ($fell(d_sda_oe) |-> !scl)
        else $error("device releases data while clock high");
    AST_DEV_HOLD: assert property ($rose(scl) |=> $stable(d_sda_oe) [*3])
        else $error("device data moves in clock high");
endmodule : svrw_props

// ===== svrw_tb_top.sv
/* Bench joining the master and the supervisor over the link.
   Assumes APB reaches the master and the bench drives the pins. */
module svrw_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0;
    logic low_voltage_flag_n = 0, sab = 0, mrn = 1, wlk = 0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h00000000, prd, s;
    logic rdy, err, kick, rstn, lvn, rsth;
    logic [1:0] aux;
    logic [4:0] tsel;
    logic [3:0] trim;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    svrw_if lnk ();
    svrw_host u_svrw_host (.i_ref_clk(clk), .i_srst(srst), .i_clk_en(1'b1),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
        .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .link(lnk), .o_watchdog_kick(kick));
    svrw_dev #(.TICK_CYC(25)) u_svrw_dev (.i_ref_clk(clk), .i_srst(srst), .i_clk_en(1'b1),
        .link(lnk), .i_vcc_low(low_voltage_flag_n), .i_sense_above(sab), .i_manual_reset_n(mrn),
        .i_watchdog_kick_in(kick), .i_write_lockout_in(wlk), .o_reset_n(rstn),
        .o_reset(rsth), .o_aux_reset_n(aux), .o_low_voltage_flag_n(lvn),
        .o_threshold_sel(tsel), .o_threshold_trim(trim));
    svrw_props u_svrw_props (.i_ref_clk(clk), .i_srst(srst), .scl(lnk.scl),
        .m_sda_o(lnk.m_sda_o), .m_sda_oe(lnk.m_sda_oe), .d_sda_o(lnk.d_sda_o),
        .d_sda_oe(lnk.d_sda_oe));
    // ==========================================================
    // Bus tasks
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr_en;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        s = prd;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic xb(input logic [11:0] c);
        apb(1'b1, 8'h00, {20'h00000, c});
        do apb(1'b0, 8'h04, 32'h00000000); while (s[0] !== 1'b0);
    endtask : xb
    task automatic wr(input logic [7:0] id, input logic [7:0] wa, input logic [7:0] d);
        xb({4'h1, id});
        xb({4'h0, wa});
        xb({4'h2, d});
    endtask : wr
    task automatic rd(input logic [7:0] id, input logic [7:0] wa);
        xb({4'h1, id});
        xb({4'h0, wa});
        xb({4'h1, id | 8'h01});
        xb(12'h600);
    endtask : rd
    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rd(8'h92, 8'h00);
        chk("cfg", 8'h58, s[15:8]);
        chk("trim", 8'h08, {4'h0, trim});
        wr(8'h92, 8'h01, 8'h25);
        rd(8'h92, 8'h01);
        chk("pr0", 8'h25, s[15:8]);
        chk("tsel", 8'h05, {3'h0, tsel});
        apb(1'b0, 8'h10, 32'h00000000);
        chk("slverr", 8'h01, {7'h00, err});
    endtask : t_regs
    task automatic t_mem();
        wr(8'hA0, 8'h10, 8'h5A);
        rd(8'hA0, 8'h10);
        chk("mem", 8'h5A, s[15:8]);
        xb(12'h380);
        chk("bad id ack", 8'h00, {7'h00, s[1]});
        wlk <= 1'b1;
        w(4);
        wr(8'h92, 8'h01, 8'h11);
        wlk <= 1'b0;
        rd(8'h92, 8'h01);
        chk("locked pr0", 8'h25, s[15:8]);
    endtask : t_mem
    task automatic t_sense();
        sab <= 1'b1;
        w(8);
        chk("flag above", 8'h00, {7'h00, lvn});
        wr(8'h92, 8'h02, 8'h28);
        w(8);
        chk("flag pol", 8'h01, {7'h00, lvn});
        xb(12'h3B0);
        chk("alt id ack", 8'h01, {7'h00, s[1]});
        xb(12'h3A0);
        chk("old id ack", 8'h00, {7'h00, s[1]});
    endtask : t_sense
    task automatic t_man();
        wr(8'h92, 8'h00, 8'h48);
        mrn <= 1'b0;
        w(4);
        mrn <= 1'b1;
        w(8);
        chk("aux on", 8'h00, {6'h00, aux});
        w(1150);
        chk("rst held", 8'h00, {7'h00, rstn});
        chk("rst hi off", 8'h00, {7'h00, rsth});
        w(150);
        chk("aux off", 8'h03, {6'h00, aux});
    endtask : t_man
    task automatic t_vcc();
        low_voltage_flag_n <= 1'b1;
        w(700);
        chk("rst low vcc", 8'h00, {7'h00, rstn});
        low_voltage_flag_n <= 1'b0;
        w(1150);
        chk("rst stretch", 8'h00, {7'h00, rstn});
        w(150);
        chk("rst end", 8'h01, {7'h00, rstn});
    endtask : t_vcc
    task automatic t_wd();
        wr(8'h92, 8'h02, 8'h0B);
        repeat (3) begin
            w(5000);
            apb(1'b1, 8'h0C, 32'h00000000);
            chk("kicked", 8'h01, {7'h00, rstn});
        end
        w(9900);
        chk("wd pending", 8'h01, {7'h00, rstn});
        w(400);
        chk("wd expired", 8'h00, {7'h00, rstn});
    endtask : t_wd
    task automatic t_lock();
        wr(8'h92, 8'h00, 8'h78);
        rd(8'h92, 8'h00);
        chk("bad code", 8'h48, s[15:8]);
        wr(8'h92, 8'h00, {4'hC, s[11:8]});
        wr(8'h92, 8'h00, 8'h58);
        rd(8'h92, 8'h00);
        chk("cfg lock", 8'hC8, s[15:8]);
        chk("trim kept", 8'h08, {4'h0, trim});
        wr(8'h92, 8'h02, 8'h40);
        wr(8'h92, 8'h01, 8'h07);
        rd(8'h92, 8'h01);
        chk("pr lock", 8'h25, s[15:8]);
    endtask : t_lock
    // ==========================================================
    // Run control
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        w(8);
        srst <= 1'b0;
        w(4);
        t_regs();
        t_mem();
        t_sense();
        t_man();
        t_vcc();
        t_wd();
        t_lock();
        end_of_test();
    end
endmodule : svrw_tb_top
